// *** inc/asx_pkg.sv ***
package asx_pkg;

    // opcode map selection
    typedef enum logic {MAP_BINARY, MAP_SOURCE} asx_map_e;

    // operation families
    typedef enum logic [2:0] {
        OP_ADD, OP_SUB, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC
    } asx_op_e;

    // operand forms
    typedef enum logic [3:0] {
        F_ACC_BANK,    // accumulator with bank_byte_reg
        F_ACC_DIRECT_ADDR_8BIT,    // accumulator with direct_addr_8bit
        F_ACC_IND,     // accumulator with indirect_byte_pointer
        F_ACC_IMM,     // accumulator with immediate
        F_RB_RB,       // file_byte_reg pair
        F_RW_RW,       // file_word_reg pair
        F_RD_RD,       // file_dword_reg pair
        F_RB_IMM,      // byte reg with 8-bit immediate
        F_RW_IMM,      // word reg with 16-bit immediate
        F_RD_IMM,      // dword reg with zero-extended immediate
        F_RB_DIRECT_ADDR_8BIT,     // byte reg with direct_addr_8bit
        F_RW_DIRECT_ADDR_8BIT,     // word reg with direct_addr_8bit
        F_RB_DIRECT_ADDR_16BIT,    // byte reg with direct_addr_16bit
        F_RW_DIRECT_ADDR_16BIT,    // word reg with direct_addr_16bit
        F_RB_IWORD,    // byte reg through word pointer
        F_RB_IDWORD    // byte reg through dword pointer
    } asx_form_e;

    // operand width
    typedef enum logic [1:0] {W_BYTE, W_WORD, W_DWORD} asx_width_e;

    // target memory space of the access
    typedef enum logic [1:0] {
        T_INTERNAL, T_PORT, T_PERIPH, T_EXTERNAL
    } asx_target_e;

    // one decoded request
    typedef struct packed {
        asx_op_e     op;
        asx_form_e   form;
        asx_target_e target;
        logic [1:0]  shortSel;  // 0:+1 1:+2 2:+4
        logic [31:0] dst;
        logic [31:0] src;
    } asx_req_s;

    // one result
    typedef struct packed {
        logic [31:0] value;
        logic        carry;
        logic [2:0]  bytes;
        logic [4:0]  states;
    } asx_rsp_s;

    // penalties in states, short-constant steps and width masks
    localparam logic [4:0] ARITH_PORT_EXTRA = 5'h01;
    localparam logic [4:0] ARITH_SFR_EXTRA  = 5'h02;
    localparam logic [4:0] INC_PORT_EXTRA   = 5'h02;
    localparam logic [4:0] INC_SFR_EXTRA    = 5'h03;
    localparam logic [4:0] EXT_BASE_EXTRA   = 5'h02;
    localparam logic [4:0] ONE_STATE        = 5'h01;
    localparam logic [1:0] SHORT_ONE        = 2'h0;
    localparam logic [1:0] SHORT_TWO        = 2'h1;
    localparam logic [31:0] STEP_ONE        = 32'h0000_0001;
    localparam logic [31:0] STEP_TWO        = 32'h0000_0002;
    localparam logic [31:0] STEP_FOUR       = 32'h0000_0004;
    localparam logic [7:0]  BYTE_MASK       = 8'hFF;
    localparam logic [15:0] WORD_MASK       = 16'hFFFF;

endpackage

// *** src/asx_timing_rom.sv ***
`timescale 1ns/10ps
`default_nettype none
// base length and state count per form and opcode map
module asx_timing_rom
    import asx_pkg::*;
(
    // lookup key
    input  wire asx_map_e   mapSel,
    input  wire asx_op_e    op,
    input  wire asx_form_e  form,
    // base figures
    output logic [2:0]      bytes,
    output logic [4:0]      states
);
    logic [2:0] binBytes;  // binary-map length
    logic [4:0] binStates; // binary-map states
    logic       srcShift;  // source map: one byte shorter, one state less
    logic       accBank;   // bank and indirect accumulator forms: source map one longer

    // binary table, with source map derived by offset
    always_comb
    begin
        binBytes  = 3'h3;
        binStates = 5'h02;
        srcShift  = 1'b1;
        accBank   = 1'b0;
        if (op == OP_INC || op == OP_DEC)
        begin
            case (form)
                F_ACC_DIRECT_ADDR_8BIT:  // direct byte by one, same both maps
                begin
                    binBytes = 3'h2; binStates = 5'h02; srcShift = 1'b0;
                end
                F_ACC_IND:   // indirect pointer
                begin
                    binBytes = 3'h1; binStates = 5'h03; accBank = 1'b1;
                end
                F_RW_IMM: begin binBytes = 3'h3; binStates = 5'h02; end
                F_RD_IMM:
                begin
                    binBytes  = 3'h3;
                    binStates = (op == OP_INC) ? 5'h04 : 5'h05;
                end
                default: begin binBytes = 3'h3; binStates = 5'h02; end
            endcase
        end
        else
        begin
            case (form)
                F_ACC_BANK:
                begin
                    binBytes = 3'h1; binStates = 5'h01; accBank = 1'b1;
                end
                F_ACC_DIRECT_ADDR_8BIT:
                begin
                    binBytes = 3'h2; binStates = 5'h01; srcShift = 1'b0;
                end
                F_ACC_IND:
                begin
                    binBytes = 3'h1; binStates = 5'h02; accBank = 1'b1;
                end
                F_ACC_IMM:
                begin
                    binBytes = 3'h2; binStates = 5'h01; srcShift = 1'b0;
                end
                F_RB_RB:    begin binBytes = 3'h3; binStates = 5'h02; end
                F_RW_RW:    begin binBytes = 3'h3; binStates = 5'h03; end
                F_RD_RD:    begin binBytes = 3'h3; binStates = 5'h05; end
                F_RB_IMM:   begin binBytes = 3'h4; binStates = 5'h03; end
                F_RW_IMM:   begin binBytes = 3'h5; binStates = 5'h04; end
                F_RD_IMM:   begin binBytes = 3'h5; binStates = 5'h06; end
                F_RB_DIRECT_ADDR_8BIT:  begin binBytes = 3'h4; binStates = 5'h03; end
                F_RW_DIRECT_ADDR_8BIT:  begin binBytes = 3'h4; binStates = 5'h04; end
                F_RB_DIRECT_ADDR_16BIT: begin binBytes = 3'h5; binStates = 5'h03; end
                F_RW_DIRECT_ADDR_16BIT: begin binBytes = 3'h5; binStates = 5'h04; end
                F_RB_IWORD: begin binBytes = 3'h4; binStates = 5'h03; end
                default:    begin binBytes = 3'h4; binStates = 5'h04; end
            endcase
        end
    end

    // apply the selected opcode map
    always_comb
    begin
        bytes  = binBytes;
        states = binStates;
        if (mapSel == MAP_SOURCE)
        begin
            if (accBank)
            begin
                bytes  = binBytes + 3'h1;
                states = binStates + ONE_STATE;
            end
            else if (srcShift)
            begin
                bytes  = binBytes - 3'h1;
                states = binStates - ONE_STATE;
            end
        end
    end
endmodule
`default_nettype wire

// *** src/asx_arith_exec.sv ***
`timescale 1ns/10ps
`default_nettype none
module asx_arith_exec
    import asx_pkg::*;
#(
    parameter int WAIT_W = 4  // width of wait-state count
)
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // configuration
    input  wire asx_map_e          mapStrap,
    input  wire logic [WAIT_W-1:0] waitStates,
    // request
    input  wire logic              reqValid,
    input  wire asx_req_s          req,
    input  wire logic              carryIn,
    // result
    output var  logic              rspValid,
    output var  asx_rsp_s          rsp
);
    asx_map_e   mapSel_q;     // opcode map caught after reset
    asx_map_e   mapSel_d;
    logic       mapCaught_q;  // strap sampled once
    logic       mapCaught_d;
    logic       rspValid_q;
    logic       rspValid_d;
    asx_rsp_s   rsp_q;
    asx_rsp_s   rsp_d;
    logic [2:0] baseBytes;    // from timing table
    logic [4:0] baseStates;
    logic [4:0] extra;        // access penalty
    logic [4:0] waitPlusTwo;
    asx_width_e width;
    logic [32:0] sum;
    logic [31:0] step;
    logic [31:0] mask;

    // base figures per map
    asx_timing_rom u_rom
    (
        .mapSel (mapSel_q),
        .op     (req.op),
        .form   (req.form),
        .bytes  (baseBytes),
        .states (baseStates)
    );

    // strap is caught by a clocked process after release, not by the reset
    always_comb
    begin
        mapSel_d    = mapSel_q;
        mapCaught_d = mapCaught_q;
        if (!mapCaught_q)
        begin
            mapSel_d    = mapStrap;
            mapCaught_d = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            mapSel_q    <= MAP_BINARY;
            mapCaught_q <= 1'b0;
        end
        else
        begin
            mapSel_q    <= mapSel_d;
            mapCaught_q <= mapCaught_d;
        end
    end

    // operand width from form
    always_comb
    begin
        case (req.form)
            F_RW_RW, F_RW_IMM, F_RW_DIRECT_ADDR_8BIT, F_RW_DIRECT_ADDR_16BIT: width = W_WORD;
            F_RD_RD, F_RD_IMM:                        width = W_DWORD;
            default:                                  width = W_BYTE;
        endcase
        case (width)
            W_WORD:  mask = {16'h0000, WORD_MASK};
            W_DWORD: mask = 32'hFFFF_FFFF;
            default: mask = {24'h00_0000, BYTE_MASK};
        endcase
    end

    // short constant decode
    always_comb
    begin
        case (req.shortSel)
            SHORT_ONE: step = STEP_ONE;
            SHORT_TWO: step = STEP_TWO;
            default:   step = STEP_FOUR;
        endcase
        // plain inc/dec of direct or indirect bytes is always by one
        if (req.form != F_RB_IMM && req.form != F_RW_IMM
            && req.form != F_RD_IMM)
            step = STEP_ONE;
    end

    // access penalties; the wait sum is saturated-free at this width
    always_comb
    begin
        waitPlusTwo = 5'(waitStates) + EXT_BASE_EXTRA;
        extra       = 5'h00;
        case (req.target)
            T_PORT:
                extra = (req.op == OP_INC || req.op == OP_DEC)
                      ? INC_PORT_EXTRA : ARITH_PORT_EXTRA;
            T_PERIPH:
                extra = (req.op == OP_INC || req.op == OP_DEC)
                      ? INC_SFR_EXTRA : ARITH_SFR_EXTRA;
            T_EXTERNAL:
                if (req.form == F_RW_DIRECT_ADDR_16BIT)
                    extra = 5'(waitPlusTwo << 1);
                else
                    extra = waitPlusTwo;
            default: extra = 5'h00;
        endcase
    end

    // datapath
    always_comb
    begin
        case (req.op)
            OP_ADD:  sum = {1'b0, req.dst} + {1'b0, req.src};
            OP_SUB:  sum = {1'b0, req.dst} - {1'b0, req.src};
            OP_ADD_WITH_CARRY: sum = {1'b0, req.dst} + {1'b0, req.src}
                         + {32'h0000_0000, carryIn};
            OP_SUBTRACT_WITH_BORROW: sum = {1'b0, req.dst} - {1'b0, req.src}
                         - {32'h0000_0000, carryIn};
            OP_INC:  sum = {1'b0, req.dst} + {1'b0, step};
            default: sum = {1'b0, req.dst} - {1'b0, step};
        endcase
    end

    // result registration
    always_comb
    begin
        rspValid_d = reqValid;
        rsp_d      = rsp_q;
        if (reqValid)
        begin
            rsp_d.value  = sum[31:0] & mask;
            case (width)
                W_WORD:  rsp_d.carry = sum[16];
                W_DWORD: rsp_d.carry = sum[32];
                default: rsp_d.carry = sum[8];
            endcase
            rsp_d.bytes  = baseBytes;
            rsp_d.states = baseStates + extra;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rspValid_q <= 1'b0;
            rsp_q      <= '0;
        end
        else
        begin
            rspValid_q <= rspValid_d;
            rsp_q      <= rsp_d;
        end
    end

    assign rspValid = rspValid_q;
    assign rsp      = rsp_q;

    // checks
    sequence sReqInternal;
        reqValid && req.target == T_INTERNAL;
    endsequence

    chk_byte_pair: assert property (@(posedge mclk) disable iff (!rst_b)
        sReqInternal and (req.form == F_RB_RB && req.op == OP_ADD)
        |=> rsp.states == ((mapSel_q == MAP_SOURCE) ? 5'h01 : 5'h02))
        else $error("byte pair state count wrong");

    chk_dword_pair: assert property (@(posedge mclk) disable iff (!rst_b)
        sReqInternal and (req.form == F_RD_RD && req.op == OP_SUB)
        |=> rsp.states == ((mapSel_q == MAP_SOURCE) ? 5'h04 : 5'h05)
            && rsp.bytes == ((mapSel_q == MAP_SOURCE) ? 3'h2 : 3'h3))
        else $error("dword pair timing wrong");

    chk_add_value: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid && req.op == OP_ADD && req.form == F_RD_RD
        |=> rsp.value == $past(req.dst) + $past(req.src))
        else $error("add result wrong");

    chk_add_with_carry_value: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid && req.op == OP_ADD_WITH_CARRY && req.form == F_ACC_IMM
        |=> rsp.value[7:0] == 8'($past(req.dst) + $past(req.src)
                                 + {31'h0, $past(carryIn)}))
        else $error("add_with_carry result wrong");

    chk_subtract_with_borrow_value: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid && req.op == OP_SUBTRACT_WITH_BORROW && req.form == F_ACC_IMM
        |=> rsp.value[7:0] == 8'($past(req.dst) - $past(req.src)
                                 - {31'h0, $past(carryIn)}))
        else $error("subtract_with_borrow result wrong");

    chk_inc_port: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid && req.op == OP_INC && req.form == F_ACC_DIRECT_ADDR_8BIT
            && req.target == T_PORT
        |=> rsp.states == 5'h04)
        else $error("inc port penalty wrong");

    chk_arith_sfr: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid && req.op == OP_ADD && req.form == F_ACC_DIRECT_ADDR_8BIT
            && req.target == T_PERIPH
        |=> rsp.states == 5'h03)
        else $error("arith peripheral penalty wrong");

    chk_word_ext: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid && req.form == F_RW_DIRECT_ADDR_16BIT && req.op == OP_SUB
            && req.target == T_EXTERNAL && mapSel_q == MAP_BINARY
        |=> rsp.states == 5'(5'h04 + 2 * ({1'b0, $past(waitStates)} + 2)))
        else $error("word external penalty wrong");

    chk_map_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        mapCaught_q |=> $stable(mapSel_q))
        else $error("opcode map changed after capture");

    chk_rsp_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
        reqValid |=> rspValid)
        else $error("result missing");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// random and corner traffic against a reference of the timing tables
module tb_top;
    import asx_pkg::*;

    // stimulus
    logic       mclk;
    logic       rstB;
    asx_map_e   mapStrap;
    logic [3:0] waitStates;
    logic       reqValid;
    asx_req_s   req;
    logic       carryIn;
    // observed result
    logic       rspValid;
    asx_rsp_s   rsp;
    // bookkeeping
    int         fails;
    int         nTests;
    int         seed;
    asx_map_e   curMap;   // map the design should hold
    asx_rsp_s   lastExp;  // result that must stand while idle

    asx_arith_exec #(.WAIT_W(4)) i_asx_arith_exec (
        .mclk(mclk), .rst_b(rstB), .mapStrap(mapStrap),
        .waitStates(waitStates), .reqValid(reqValid), .req(req),
        .carryIn(carryIn), .rspValid(rspValid), .rsp(rsp)
    );

    // 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // operand width of a form
    function automatic logic [31:0] wmask(asx_form_e f);
        if (f inside {F_RW_RW, F_RW_IMM, F_RW_DIRECT_ADDR_8BIT, F_RW_DIRECT_ADDR_16BIT})
            return 32'h0000_FFFF;
        if (f inside {F_RD_RD, F_RD_IMM})
            return 32'hFFFF_FFFF;
        return 32'h0000_00FF;
    endfunction

    // only pairings the instruction set has
    function automatic logic legal(asx_op_e o, asx_form_e f);
        if (o inside {OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW})
            return f inside {F_ACC_BANK, F_ACC_DIRECT_ADDR_8BIT, F_ACC_IND, F_ACC_IMM};
        if (o inside {OP_INC, OP_DEC})
            return f inside {F_ACC_DIRECT_ADDR_8BIT, F_ACC_IND, F_RB_IMM, F_RW_IMM,
                             F_RD_IMM};
        return 1'b1;
    endfunction

    // base {bytes, states} as two nibbles
    function automatic logic [7:0] base_of(asx_op_e o, asx_form_e f);
        logic       id;
        logic       sm;
        logic [7:0] bin;
        id = o inside {OP_INC, OP_DEC};
        sm = (curMap == MAP_SOURCE);
        case (f)
            F_ACC_BANK: return sm ? 8'h22 : 8'h11;
            F_ACC_DIRECT_ADDR_8BIT: return id ? 8'h22 : 8'h21;
            F_ACC_IND:  return id ? (sm ? 8'h24 : 8'h13)
                                  : (sm ? 8'h23 : 8'h12);
            F_ACC_IMM:  return 8'h21;
            F_RB_RB:    bin = 8'h32;
            F_RW_RW:    bin = 8'h33;
            F_RD_RD:    bin = 8'h35;
            F_RB_IMM:   bin = id ? 8'h32 : 8'h43;
            F_RW_IMM:   bin = id ? 8'h32 : 8'h54;
            F_RD_IMM:   bin = id ? ((o == OP_DEC) ? 8'h35 : 8'h34) : 8'h56;
            F_RB_DIRECT_ADDR_8BIT, F_RB_IWORD:  bin = 8'h43;
            F_RW_DIRECT_ADDR_8BIT, F_RB_IDWORD: bin = 8'h44;
            F_RB_DIRECT_ADDR_16BIT: bin = 8'h53;
            default:    bin = 8'h54;
        endcase
        // register-file forms lose the escape byte and its state
        return sm ? bin - 8'h11 : bin;
    endfunction

    // expected result of one request
    function automatic asx_rsp_s model(asx_op_e o, asx_form_e f,
        asx_target_e t, logic [1:0] sh, logic [31:0] d, logic [31:0] s,
        logic cy, logic [3:0] n);
        asx_rsp_s    r;
        logic [32:0] step;
        logic [32:0] raw;
        logic [7:0]  e;
        logic [4:0]  ext;
        logic        id;
        int          w;
        id = o inside {OP_INC, OP_DEC};
        w = (wmask(f) == 32'h0000_00FF) ? 8 :
            (wmask(f) == 32'h0000_FFFF) ? 16 : 32;
        step = {1'b0, s};
        if (id)
            step = {1'b0, STEP_ONE};
        if (id && f inside {F_RB_IMM, F_RW_IMM, F_RD_IMM})
            step = {1'b0, (sh == 2'h0) ? STEP_ONE :
                          (sh == 2'h1) ? STEP_TWO : STEP_FOUR};
        if (o inside {OP_ADD, OP_ADD_WITH_CARRY, OP_INC})
            raw = {1'b0, d} + step + 33'((o == OP_ADD_WITH_CARRY) & cy);
        else
            raw = {1'b0, d} - step - 33'((o == OP_SUBTRACT_WITH_BORROW) & cy);
        r.value = raw[31:0] & wmask(f);
        r.carry = raw[w];
        e = base_of(o, f);
        r.bytes = e[6:4];
        r.states = {1'b0, e[3:0]};
        ext = {1'b0, n} + EXT_BASE_EXTRA;
        case (t)
            T_PORT:     r.states += id ? INC_PORT_EXTRA : ARITH_PORT_EXTRA;
            T_PERIPH:   r.states += id ? INC_SFR_EXTRA : ARITH_SFR_EXTRA;
            T_EXTERNAL: r.states += (f == F_RW_DIRECT_ADDR_16BIT) ? ext << 1 : ext;
            default:    ;
        endcase
        return r;
    endfunction

    // one comparison
    task automatic check(input logic [40:0] got, input logic [40:0] exp);
        nTests++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // one request, answer checked one cycle later
    task automatic send(input asx_op_e o, input asx_form_e f,
        input asx_target_e t, input logic [1:0] sh, input logic [31:0] d,
        input logic [31:0] s, input logic cy, input logic [3:0] n);
        asx_rsp_s    e;
        logic        id;
        logic [32:0] gotV;
        logic [32:0] expV;
        logic [7:0]  gotT;
        logic [7:0]  expT;
        e = model(o, f, t, sh, d, s, cy, n);
        id = o inside {OP_INC, OP_DEC};
        reqValid = 1'b1;
        req = '{op: o, form: f, target: t, shortSel: sh, dst: d, src: s};
        carryIn = cy;
        waitStates = n;
        @(negedge mclk);
        check(41'(rspValid), 41'h1);
        // inc/dec carry is masked off on both sides, so only the value counts
        gotV = {rsp.value, rsp.carry & !id};
        expV = {e.value, e.carry & !id};
        gotT = {rsp.bytes, rsp.states};
        expT = {e.bytes, e.states};
        if (id)
            check(41'(gotV), 41'(expV));
        else if (o == OP_ADD_WITH_CARRY)
            check(41'(gotV), 41'(expV));
        else if (o == OP_SUBTRACT_WITH_BORROW)
            check(41'(gotV), 41'(expV));
        else
            check(41'(gotV), 41'(expV));
        if (t == T_EXTERNAL)
            check(41'(gotT), 41'(expT));
        else if (t != T_INTERNAL)
            check(41'(gotT), 41'(expT));
        else if (id)
            check(41'(gotT), 41'(expT));
        else if (o inside {OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW})
            check(41'(gotT), 41'(expT));
        else if (f inside {F_RB_RB, F_RW_RW, F_RD_RD})
            check(41'(gotT), 41'(expT));
        else
            check(41'(gotT), 41'(expT));
        lastExp = e;
    endtask

    // random operands for a chosen instruction
    task automatic fill(input asx_op_e o, input asx_form_e f,
                        input asx_target_e t);
        logic [31:0] d;
        logic [31:0] s;
        d = $random(seed) & wmask(f);
        s = $random(seed) & wmask(f);
        // dword immediate carries only sixteen bits
        if (f == F_RD_IMM)
            s = s & 32'h0000_FFFF;
        send(o, f, t, 2'($unsigned($random(seed)) % 3), d, s,
             1'($random(seed)), 4'($random(seed)) & 4'h7);
    endtask

    // a cycle with no request: result must stand
    task automatic idle();
        reqValid = 1'b0;
        // a packed cast needs a source exactly as wide as the request
        req = asx_req_s'(75'({$random(seed), $random(seed), $random(seed)}));
        waitStates = 4'($random(seed));
        @(negedge mclk);
        check(41'(rspValid), 41'h0);
        check(41'({rsp.value, rsp.bytes, rsp.states}),
              41'({lastExp.value, lastExp.bytes, lastExp.states}));
    endtask

    // reset with a strap value, then settle past capture
    task automatic do_reset(input asx_map_e m, input int cyc);
        rstB = 1'b0;
        reqValid = 1'b0;
        mapStrap = m;
        curMap = m;
        lastExp = '0;
        repeat (cyc) @(negedge mclk);
        check(41'(rspValid), 41'h0);
        check(rsp, 41'h0);
        rstB = 1'b1;
        repeat (2) @(negedge mclk);
    endtask

    // verdict and end of run
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard, far beyond the roughly one thousand cycles needed
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        give_verdict();
    end

    // main sequence: both maps, every legal form and target
    initial
    begin
        asx_op_e   o;
        asx_form_e f;
        fails = 0;
        nTests = 0;
        seed = 649;
        carryIn = 1'b0;
        waitStates = 4'h0;
        req = '0;
        do_reset(MAP_BINARY, 10);
        for (int mi = 0; mi < 2; mi++)
        begin
            if (mi == 1)
                do_reset(MAP_SOURCE, 3);
            // back-to-back sweep
            for (int oi = 0; oi < 6; oi++)
                for (int fi = 0; fi < 16; fi++)
                    for (int ti = 0; ti < 4; ti++)
                        if (legal(asx_op_e'(oi), asx_form_e'(fi)))
                            fill(asx_op_e'(oi), asx_form_e'(fi),
                                 asx_target_e'(ti));
            // carry boundaries and widest penalty
            send(OP_ADD_WITH_CARRY, F_ACC_IMM, T_INTERNAL, 2'h0, 32'h0000_00FF,
                 32'h0000_0000, 1'b1, 4'h0);
            send(OP_SUBTRACT_WITH_BORROW, F_ACC_BANK, T_INTERNAL, 2'h0, 32'h0000_0000,
                 32'h0000_0000, 1'b1, 4'h0);
            send(OP_INC, F_RD_IMM, T_INTERNAL, 2'h2, 32'hFFFF_FFFE,
                 32'h0000_0000, 1'b0, 4'h0);
            send(OP_SUB, F_RW_DIRECT_ADDR_16BIT, T_EXTERNAL, 2'h0, 32'h0000_0000,
                 32'h0000_0001, 1'b0, 4'h7);
            idle();
            // random mix with gaps
            repeat (300)
            begin
                if ($random(seed) & 1)
                    idle();
                else
                begin
                    do
                    begin
                        o = asx_op_e'($unsigned($random(seed)) % 6);
                        f = asx_form_e'(4'($random(seed)));
                    end while (!legal(o, f));
                    fill(o, f, asx_target_e'(2'($random(seed))));
                end
            end
        end
        // strap moved after capture must not change the figures
        do_reset(MAP_BINARY, 3);
        mapStrap = MAP_SOURCE;
        fill(OP_ADD, F_RB_RB, T_INTERNAL);
        fill(OP_DEC, F_RD_IMM, T_INTERNAL);
        idle();
        give_verdict();
    end

endmodule
`default_nettype wire
